//--- rtl/ocpwm_pkg.sv
// Constants, field layout and mode codes of the compare/PWM channel.
// Assumes a single system clock; all users write ocpwm_pkg::name.
package ocpwm_pkg;
  // ==========================================================
  // Widths and register map
  localparam int          TB_W      = 16;
  localparam int          QUARTERS  = 4;
  localparam int          ADDR_W    = 12;
  localparam logic [11:0] ADDR_CON1 = 12'h000;
  localparam logic [11:0] ADDR_CON2 = 12'h004;
  localparam logic [11:0] ADDR_PRI  = 12'h008;
  localparam logic [11:0] ADDR_SEC  = 12'h00C;
  localparam logic [11:0] ADDR_PER  = 12'h010;
  localparam logic [11:0] ADDR_CNT  = 12'h014;
  // ==========================================================
  // Control one fields
  localparam int MODE_LSB    = 0;
  localparam int TRIGCLR_BIT = 3;
  localparam int FSTAT_LSB   = 4;
  localparam int FEN_LSB     = 7;
  localparam int TSEL_LSB    = 10;
  localparam int IDLE_BIT    = 13;
  // ==========================================================
  // Control two fields
  localparam int TRIG_BIT    = 6;
  localparam int DLY_LSB     = 9;
  localparam int FLVL_BIT    = 14;
  localparam int FHOLD_BIT   = 15;
  localparam logic [15:0] CON_RST = 16'h0000;
  // ==========================================================
  // Time-base select codes and mode codes
  localparam logic [2:0] TSEL_LAST_TMR = 3'h3;
  localparam logic [2:0] TSEL_T1       = 3'h4;
  localparam logic [2:0] TSEL_SYS      = 3'h7;
  typedef enum logic [2:0] {
    OCPWM_DIS  = 3'b000,
    OCPWM_SSHI = 3'b001,
    OCPWM_SSLO = 3'b010,
    OCPWM_TOG  = 3'b011,
    OCPWM_DSS  = 3'b100,
    OCPWM_DCP  = 3'b101,
    OCPWM_EPWM = 3'b110,
    OCPWM_CPWM = 3'b111
  } ocpwm_mode_e;
endpackage

//--- rtl/ocpwm_tick_sel.sv
// Time-base source selection and idle gating.
// Timer ticks arrive as one-cycle enables synchronous to ref_clk.
module ocpwm_tick_sel (
  input  wire logic [2:0] tsel,
  input  wire logic [4:0] timer_tick,
  input  wire logic       halt,
  output logic            tick
);
  logic [2:0] tmr_idx;
  logic       raw;
  // Index 0 is timer one, 1..4 are timers two to five
  assign tmr_idx = (tsel == ocpwm_pkg::TSEL_T1) ? 3'h0 : 3'(tsel + 3'h1);
  assign raw = (tsel == ocpwm_pkg::TSEL_SYS) ? 1'b1 :
               (tsel <= ocpwm_pkg::TSEL_T1) ? timer_tick[tmr_idx] :
               1'b0;
  assign tick = raw & ~halt;
endmodule

//--- rtl/ocpwm_edge_dly.sv
// Output level register with quarter-cycle falling-edge pattern.
// Assumes a 4x serializer downstream consumes phase, slot 0 first.
module ocpwm_edge_dly (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       lvl_d,
  input  wire logic [1:0] dly,
  input  wire logic       dly_en,
  output logic            pin_q,
  output logic [3:0]      phase_q
);
  logic       fall;
  logic [3:0] phase_d;
  // Delay is always in quarters of ref_clk, whatever the tick rate
  assign fall = pin_q & ~lvl_d & dly_en & (dly != 2'h0);
  assign phase_d = fall ? 4'((4'h1 << dly) - 4'h1)
                        : {ocpwm_pkg::QUARTERS{lvl_d}};
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pin_q   <= 1'b0;
      phase_q <= 4'h0;
    end
    else
    begin
      pin_q   <= lvl_d;
      phase_q <= phase_d;
    end
  end
endmodule

//--- rtl/ocpwm_unit.sv
// Output compare / PWM channel with APB register slave.
// Assumes timer ticks, idle, and fault inputs synchronous to ref_clk.
//
// Chosen here: the APB interface to the registers and the register addresses.
module ocpwm_unit #(
  parameter int CHANNEL = 1
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  timer_tick,
  input  wire logic        cpu_idle,
  input  wire logic        fault_input_a,
  input  wire logic        fault_input_b,
  input  wire logic [2:0]  cmp_fault,
  output logic             compare_output_pin,
  output logic [3:0]       compare_output_phase
);
  if (CHANNEL < 1 || CHANNEL > 5)
  begin : g_bad
    $error("CHANNEL must be 1 to 5");
  end

  localparam int W = ocpwm_pkg::TB_W;

  // ==========================================================
  // Helpers
  function automatic logic [1:0] cmp_index(input int ch);
    cmp_index = 2'((ch - 1) / 2);
  endfunction

  function automatic logic [31:0] fld(input logic [15:0] v, input int lsb);
    fld = 32'(v) << lsb;
  endfunction

  // ==========================================================
  // Registers
  ocpwm_pkg::ocpwm_mode_e mode_q;
  logic         trig_clr_q;
  logic [2:0]   fstat_q;
  logic [2:0]   fen_q;
  logic [2:0]   tsel_q;
  logic         idle_q;
  logic         fhold_q;
  logic         flvl_q;
  logic [1:0]   dly_q;
  logic         trig_q;
  logic [W-1:0] pri_q;
  logic [W-1:0] sec_q;
  logic [W-1:0] per_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] pri_buf_q;
  logic [W-1:0] sec_buf_q;
  logic [1:0]   dly_buf_q;
  logic         done_q;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;

  // ==========================================================
  // APB decode
  logic        setup;
  logic        wr;
  logic        hit_con1;
  logic        hit_con2;
  logic        hit_pri;
  logic        hit_sec;
  logic        hit_per;
  logic        hit_cnt;
  logic        mapped;
  logic        con1_wr;
  logic        con2_wr;
  logic [31:0] rd_con1;
  logic [31:0] rd_con2;
  logic [31:0] rd_mux;

  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign hit_con1 = paddr == ocpwm_pkg::ADDR_CON1;
  assign hit_con2 = paddr == ocpwm_pkg::ADDR_CON2;
  assign hit_pri  = paddr == ocpwm_pkg::ADDR_PRI;
  assign hit_sec  = paddr == ocpwm_pkg::ADDR_SEC;
  assign hit_per  = paddr == ocpwm_pkg::ADDR_PER;
  assign hit_cnt  = paddr == ocpwm_pkg::ADDR_CNT;
  assign mapped   = hit_con1 | hit_con2 | hit_pri | hit_sec |
                    hit_per | hit_cnt;
  assign con1_wr  = wr & hit_con1;
  assign con2_wr  = wr & hit_con2;

  // Bits 15:14 of control one are never assembled, so read zero
  assign rd_con1 = fld(16'(mode_q), ocpwm_pkg::MODE_LSB)
                 | fld(16'(trig_clr_q), ocpwm_pkg::TRIGCLR_BIT)
                 | fld(16'(fstat_q), ocpwm_pkg::FSTAT_LSB)
                 | fld(16'(fen_q), ocpwm_pkg::FEN_LSB)
                 | fld(16'(tsel_q), ocpwm_pkg::TSEL_LSB)
                 | fld(16'(idle_q), ocpwm_pkg::IDLE_BIT);
  assign rd_con2 = fld(16'(trig_q), ocpwm_pkg::TRIG_BIT)
                 | fld(16'(dly_q), ocpwm_pkg::DLY_LSB)
                 | fld(16'(flvl_q), ocpwm_pkg::FLVL_BIT)
                 | fld(16'(fhold_q), ocpwm_pkg::FHOLD_BIT);
  assign rd_mux = hit_con1 ? rd_con1 :
                  hit_con2 ? rd_con2 :
                  hit_pri  ? 32'(pri_q) :
                  hit_sec  ? 32'(sec_q) :
                  hit_per  ? 32'(per_q) :
                  hit_cnt  ? 32'(cnt_q) : 32'h0000_0000;

  // Zero wait states: pready rises for the access cycle only
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= setup ? rd_mux : prdata_q;
    end
  end

  // ==========================================================
  // Time base
  logic         tick;
  logic         pwm;
  logic         per_end;
  logic [W-1:0] pri_eff;
  logic [W-1:0] sec_eff;
  logic [1:0]   dly_eff;
  logic         pm;
  logic         sm;
  logic [W-1:0] cnt_d;

  ocpwm_tick_sel u_tick (
    .tsel       (tsel_q),
    .timer_tick (timer_tick),
    .halt       (idle_q & cpu_idle),
    .tick       (tick)
  );

  assign pwm     = (mode_q == ocpwm_pkg::OCPWM_EPWM) |
                   (mode_q == ocpwm_pkg::OCPWM_CPWM);
  assign per_end = tick & (cnt_q == per_q);
  // Outside PWM the buffers follow the registers, so writes act at once
  assign pri_eff = pwm ? pri_buf_q : pri_q;
  assign sec_eff = pwm ? sec_buf_q : sec_q;
  assign dly_eff = pwm ? dly_buf_q : dly_q;
  assign pm      = tick & (cnt_q == pri_eff);
  assign sm      = tick & (cnt_q == sec_eff);
  assign cnt_d   = (mode_q == ocpwm_pkg::OCPWM_DIS) ? '0 :
                   per_end ? '0 :
                   tick ? W'(cnt_q + 1'b1) : cnt_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_q     <= '0;
      pri_buf_q <= '0;
      sec_buf_q <= '0;
      dly_buf_q <= 2'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
      if (!pwm || per_end)
      begin
        pri_buf_q <= pri_q;
        sec_buf_q <= sec_q;
        dly_buf_q <= dly_q;
      end
    end
  end

  // ==========================================================
  // Faults
  logic [2:0] fsrc;
  logic [2:0] fset;
  logic [2:0] fclr;
  logic       fault_act;

  assign fsrc = fen_q & {cmp_fault[cmp_index(CHANNEL)],
                         fault_input_b, fault_input_a};
  assign fset = (mode_q == ocpwm_pkg::OCPWM_CPWM) ? fsrc : 3'h0;
  // Hold mode needs software to write zero once the source is gone
  assign fclr = ~fsrc & (fhold_q
              ? (con1_wr ? ~pwdata[ocpwm_pkg::FSTAT_LSB +: 3] : 3'h0)
              : {3{per_end}});
  assign fault_act = |(fstat_q | fset);

  // ==========================================================
  // Output sequencing
  logic [2:0] new_mode;
  logic       cur;
  logic       lvl_mode;
  logic       lvl_d;
  logic       done_d;

  assign new_mode = pwdata[ocpwm_pkg::MODE_LSB +: 3];
  assign cur      = compare_output_pin;

  always_comb
  begin
    lvl_mode = 1'b0;
    unique case (mode_q)
      ocpwm_pkg::OCPWM_DIS:  lvl_mode = 1'b0;
      ocpwm_pkg::OCPWM_SSHI: lvl_mode = cur | pm;
      ocpwm_pkg::OCPWM_SSLO: lvl_mode = cur & ~pm;
      ocpwm_pkg::OCPWM_TOG:  lvl_mode = cur ^ pm;
      ocpwm_pkg::OCPWM_DSS:
        lvl_mode = done_q ? cur : (cur ? ~sm : pm);
      ocpwm_pkg::OCPWM_DCP:  lvl_mode = cur ? ~sm : pm;
      ocpwm_pkg::OCPWM_EPWM:
        lvl_mode = cnt_q < sec_eff;
      ocpwm_pkg::OCPWM_CPWM:
        lvl_mode = (cnt_q >= pri_eff) && (cnt_q < sec_eff);
    endcase
  end

  // A control write restarts single shots at their initial level
  assign lvl_d = con1_wr ? (new_mode == 3'(ocpwm_pkg::OCPWM_SSLO)) :
                 (mode_q == ocpwm_pkg::OCPWM_CPWM && fault_act) ?
                 flvl_q : lvl_mode;
  assign done_d = ~con1_wr & (done_q |
                  ((mode_q == ocpwm_pkg::OCPWM_DSS) & cur & sm));

  ocpwm_edge_dly u_edge (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .lvl_d   (lvl_d),
    .dly     (dly_eff),
    .dly_en  (mode_q != ocpwm_pkg::OCPWM_SSHI),
    .pin_q   (compare_output_pin),
    .phase_q (compare_output_phase)
  );

  // ==========================================================
  // Control state
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      mode_q     <= ocpwm_pkg::OCPWM_DIS;
      trig_clr_q <= 1'b0;
      fstat_q    <= 3'h0;
      fen_q      <= 3'h0;
      tsel_q     <= 3'h0;
      idle_q     <= 1'b0;
      fhold_q    <= 1'b0;
      flvl_q     <= 1'b0;
      dly_q      <= 2'h0;
      trig_q     <= 1'b0;
      pri_q      <= '0;
      sec_q      <= '0;
      per_q      <= '0;
      done_q     <= 1'b0;
    end
    else
    begin
      done_q  <= done_d;
      fstat_q <= fset | (fstat_q & ~fclr);
      if (con1_wr)
      begin
        mode_q     <= ocpwm_pkg::ocpwm_mode_e'(new_mode);
        trig_clr_q <= pwdata[ocpwm_pkg::TRIGCLR_BIT];
        fen_q      <= pwdata[ocpwm_pkg::FEN_LSB +: 3];
        tsel_q     <= pwdata[ocpwm_pkg::TSEL_LSB +: 3];
        idle_q     <= pwdata[ocpwm_pkg::IDLE_BIT];
      end
      if (con2_wr)
      begin
        fhold_q <= pwdata[ocpwm_pkg::FHOLD_BIT];
        flvl_q  <= pwdata[ocpwm_pkg::FLVL_BIT];
        dly_q   <= pwdata[ocpwm_pkg::DLY_LSB +: 2];
        trig_q  <= pwdata[ocpwm_pkg::TRIG_BIT];
      end
      else if (trig_clr_q && sm)
        trig_q <= 1'b0;
      if (wr && hit_pri)
        pri_q <= pwdata[W-1:0];
      if (wr && hit_sec)
        sec_q <= pwdata[W-1:0];
      if (wr && hit_per)
        per_q <= pwdata[W-1:0];
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================
  // Checks
  sequence s_period_end;
    tick && (cnt_q == per_q) && (mode_q != ocpwm_pkg::OCPWM_DIS);
  endsequence

  sequence s_idle_halt;
    idle_q && cpu_idle && !con1_wr &&
    (mode_q != ocpwm_pkg::OCPWM_DIS);
  endsequence

  a_period_wrap: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_period_end |=> cnt_q == '0)
    else $error("counter did not restart after period");

  a_count_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick && cnt_q != per_q && mode_q != ocpwm_pkg::OCPWM_DIS && !con1_wr
    |=> cnt_q == W'($past(cnt_q) + 1'b1))
    else $error("counter did not advance on tick");

  a_idle_freeze: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_idle_halt ##1 s_idle_halt |-> $stable(cnt_q))
    else $error("counter moved while halted in idle");

  a_duty_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s_period_end and pwm) |=> sec_buf_q == $past(sec_q))
    else $error("duty not latched at period end");

  a_duty_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pwm && !per_end |=> $stable(sec_buf_q) && $stable(dly_buf_q))
    else $error("buffered duty changed mid period");

  a_zero_duty: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pwm && !fault_act && !con1_wr && pri_eff == '0 && sec_eff == '0
    && per_q == '0 |=> !compare_output_pin)
    else $error("output high at zero duty");

  a_full_duty: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode_q == ocpwm_pkg::OCPWM_EPWM && !con1_wr && sec_eff > per_q
    && cnt_q <= per_q |=> compare_output_pin)
    else $error("output low at full duty");

  a_disabled_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode_q == ocpwm_pkg::OCPWM_DIS && !con1_wr
    |=> !compare_output_pin)
    else $error("disabled channel drove high");

  a_fault_force: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode_q == ocpwm_pkg::OCPWM_CPWM && fault_act && !con1_wr
    |=> compare_output_pin == $past(flvl_q))
    else $error("fault did not force output level");

  a_fault_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fset[0] |=> fstat_q[0] ##1 (fstat_q[0] || !$past(fstat_q[0]) ||
    !$past(fsrc[0])))
    else $error("fault status not set or lost early");

  a_trig_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_clr_q && sm && !con2_wr |=> !trig_q)
    else $error("trigger status not cleared on match");

  a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    setup && hit_con1 |=> prdata[31:14] == '0)
    else $error("unimplemented bits read nonzero");

  a_one_shot: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode_q == ocpwm_pkg::OCPWM_DSS && done_q && !con1_wr
    |=> !compare_output_pin)
    else $error("second pulse in single-shot mode");
endmodule

//--- tb/ocpwm_load.sv
// Load model hanging on the compare output pin and its phase pattern.
// Assumes registered design outputs sampled on the ref_clk rising edge.
module ocpwm_load (
  input  wire logic       ref_clk,
  input  wire logic       clr,
  input  wire logic       pin,
  input  wire logic [3:0] phase,
  output logic [7:0]      high_cnt,
  output logic [7:0]      rise_cnt,
  output logic [3:0]      partial
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Window counters
  logic prev;
  always @(posedge ref_clk)
  begin
    prev <= pin;
    if (clr)
    begin
      high_cnt <= 8'h00;
      rise_cnt <= 8'h00;
      partial  <= 4'h0;
    end
    else
    begin
      high_cnt <= high_cnt + {7'h00, pin};
      if (pin && !prev)
        rise_cnt <= rise_cnt + 8'h01;
      // Only a delayed falling cycle splits the pattern
      if (phase !== {4{pin}})
        partial <= phase;
    end
  end
endmodule

//--- tb/output_compare_pwm_unit_tb_top.sv
// Self-checking bench: APB register access and pin waveform counts.
// Assumes ocpwm_pkg and ocpwm_load are compiled first.
module output_compare_pwm_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  timer_tick = 5'h00;
  logic [4:0]  tmask = 5'h00;
  logic        tdiv = 1'b0;
  logic        cpu_idle = 1'b0;
  logic        fault_input_a = 1'b0;
  logic        fault_input_b = 1'b0;
  logic [2:0]  cmp_fault = 3'h0;
  logic        pin;
  logic [3:0]  phase;
  logic        clr = 1'b0;
  logic [7:0]  ld_high;
  logic [7:0]  ld_rise;
  logic [3:0]  ld_part;
  int          mismatches = 0;
  int          checked = 0;

  always #4 ref_clk = ~ref_clk;

  // Timer enables every second cycle, only on masked sources
  always @(posedge ref_clk)
  begin
    tdiv <= ~tdiv;
    timer_tick <= tdiv ? tmask : 5'h00;
  end

  ocpwm_unit dut (
    .ref_clk              (ref_clk),
    .sys_rst              (sys_rst),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .timer_tick           (timer_tick),
    .cpu_idle             (cpu_idle),
    .fault_input_a        (fault_input_a),
    .fault_input_b        (fault_input_b),
    .cmp_fault            (cmp_fault),
    .compare_output_pin   (pin),
    .compare_output_phase (phase)
  );

  ocpwm_load load (
    .ref_clk  (ref_clk),
    .clr      (clr),
    .pin      (pin),
    .phase    (phase),
    .high_cnt (ld_high),
    .rise_cnt (ld_rise),
    .partial  (ld_part)
  );

  // ==========================================================
  // Compare and report
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // APB master
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Values read here are those sampled by this edge
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (n >= 64)
      mismatches++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {16'h0000, d}, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk32(r, exp);
  endtask

  // ==========================================================
  // Waveform run: park in mode 000, program, count a window
  task automatic zap;
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask

  task automatic run(input logic [15:0] c1, input bit warm,
                     input logic [7:0] er, input logic [7:0] eh);
    wr(ocpwm_pkg::ADDR_CON1, 16'h0000);
    if (!warm)
      zap();
    wr(ocpwm_pkg::ADDR_CON1, c1);
    // Warm runs skip the first period, where an old fault status can still force the pin
    if (warm)
    begin
      repeat (12) @(posedge ref_clk);
      zap();
    end
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    chk8(ld_rise, er);
    if (eh !== 8'hFF)
      chk8(ld_high, eh);
    // Hand back on a rising edge so callers drive there
    @(posedge ref_clk);
  endtask

  initial
  begin
    #200000;
    mismatches++;
    final_report();
  end

  // ==========================================================
  // Tests
  initial
  begin
    logic [31:0] r;
    logic        e;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(ocpwm_pkg::ADDR_CON1, 32'h0);
    rd(ocpwm_pkg::ADDR_CON2, 32'h0);
    wr(ocpwm_pkg::ADDR_CON1, 16'hFFFF);
    rd(ocpwm_pkg::ADDR_CON1, 32'h3F8F);
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk32({31'h0, e}, 32'h1);
    chk32(r, 32'h0);
    wr(ocpwm_pkg::ADDR_PRI, 16'h0001);
    wr(ocpwm_pkg::ADDR_SEC, 16'h0002);
    wr(ocpwm_pkg::ADDR_PER, 16'h0003);
    run(16'h1C00, 1'b0, 8'h00, 8'h00);
    run(16'h1C01, 1'b0, 8'h01, 8'hFF);
    chk8({7'h00, pin}, 8'h01);
    run(16'h1C02, 1'b0, 8'h01, 8'hFF);
    chk8({7'h00, pin}, 8'h00);
    run(16'h1C03, 1'b1, 8'h02, 8'h08);
    run(16'h1C04, 1'b0, 8'h01, 8'h01);
    run(16'h1C05, 1'b1, 8'h04, 8'h04);
    run(16'h1C06, 1'b1, 8'h04, 8'h08);
    run(16'h1C07, 1'b1, 8'h04, 8'h04);
    wr(ocpwm_pkg::ADDR_PER, 16'h0007);
    wr(ocpwm_pkg::ADDR_SEC, 16'h0004);
    run(16'h1C06, 1'b1, 8'h02, 8'h08);
    wr(ocpwm_pkg::ADDR_PER, 16'h0003);
    wr(ocpwm_pkg::ADDR_SEC, 16'h0005);
    run(16'h1C06, 1'b1, 8'h00, 8'h10);
    wr(ocpwm_pkg::ADDR_PRI, 16'h0000);
    wr(ocpwm_pkg::ADDR_SEC, 16'h0000);
    wr(ocpwm_pkg::ADDR_PER, 16'h0000);
    run(16'h1C06, 1'b1, 8'h00, 8'h00);
    wr(ocpwm_pkg::ADDR_PRI, 16'h0001);
    wr(ocpwm_pkg::ADDR_SEC, 16'h0002);
    wr(ocpwm_pkg::ADDR_PER, 16'h0003);
    for (int t = 0; t < 7; t++)
    begin
      tmask <= (t == 4) ? 5'h01 : (t < 4) ? 5'(5'h02 << t) : 5'h1F;
      run(16'(16'h0006 | (t << 10)), 1'b1, (t < 5) ? 8'h02 : 8'h00,
          (t < 5) ? 8'h08 : 8'h10);
    end
    cpu_idle <= 1'b1;
    run(16'h3C06, 1'b1, 8'h00, 8'h10);
    run(16'h1C06, 1'b1, 8'h04, 8'h08);
    cpu_idle <= 1'b0;
    wr(ocpwm_pkg::ADDR_CON2, 16'h0040);
    run(16'h1C06, 1'b1, 8'h04, 8'h08);
    rd(ocpwm_pkg::ADDR_CON2, 32'h40);
    wr(ocpwm_pkg::ADDR_CON2, 16'h0040);
    run(16'h1C0E, 1'b1, 8'h04, 8'h08);
    rd(ocpwm_pkg::ADDR_CON2, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      wr(ocpwm_pkg::ADDR_CON2, 16'(c << 9));
      run(16'h1C06, 1'b1, 8'h04, 8'h08);
      chk8({4'h0, ld_part}, 8'((1 << c) - 1));
    end
    wr(ocpwm_pkg::ADDR_CON2, 16'h0600);
    run(16'h1C01, 1'b0, 8'h01, 8'hFF);
    chk8({4'h0, ld_part}, 8'h00);
    // Re-arming drops the high pin: a fall that must stay undelayed
    wr(ocpwm_pkg::ADDR_CON1, 16'h1C01);
    repeat (2) @(posedge ref_clk);
    chk8({4'h0, ld_part}, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(ocpwm_pkg::ADDR_CON2, (i == 1) ? 16'h4000 : 16'h0000);
      fault_input_a <= (i == 0);
      fault_input_b <= (i == 1);
      cmp_fault     <= {2'b00, i == 2};
      run(16'h1C07, 1'b1, 8'h04, 8'h04);
      run(16'(16'h1C07 | (16'h0080 << i)), 1'b1, 8'h00,
          (i == 1) ? 8'h10 : 8'h00);
      rd(ocpwm_pkg::ADDR_CON1,
         32'h1C07 | (32'h0080 << i) | (32'h0010 << i));
      fault_input_a <= 1'b0;
      fault_input_b <= 1'b0;
      cmp_fault     <= 3'h0;
      run(16'(16'h1C07 | (16'h0080 << i)), 1'b1, 8'h04, 8'h04);
      rd(ocpwm_pkg::ADDR_CON1, 32'h1C07 | (32'h0080 << i));
    end
    // Hold mode: status survives periods until software clears it
    wr(ocpwm_pkg::ADDR_CON2, 16'h8000);
    fault_input_a <= 1'b1;
    run(16'h1C87, 1'b1, 8'h00, 8'h00);
    fault_input_a <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rd(ocpwm_pkg::ADDR_CON1, 32'h1C97);
    wr(ocpwm_pkg::ADDR_CON1, 16'h1C87);
    rd(ocpwm_pkg::ADDR_CON1, 32'h1C87);
    final_report();
  end
endmodule
